// file: pio01_int_edge.sv
// Purpose: falling edge detect for the shared interrupt pin
// Assumes: LEVEL is already synchronised to CLK
// Notes: the edge is swallowed while the pin enable is clear
module pio01_int_edge (
  input wire logic CLK,
  input wire logic RST,
  input wire logic LEVEL,
  input wire logic ENABLE,
  output logic FALL
);
  // previous level, idles high
  logic prev;

  // remember last level
  always_ff @(posedge CLK) begin
    if (RST) begin
      prev <= 1'b1;
    end else begin
      prev <= LEVEL;
    end
  end

  // pulse on a high to low step only when enabled
  assign FALL = ENABLE & prev & ~LEVEL;

  // a falling step seen while enabled
  sequence fall_seq;
    LEVEL ##1 (!LEVEL && ENABLE);
  endsequence

  edge_pulse_a: assert property (@(posedge CLK) disable iff (RST)
    fall_seq |-> FALL)
    else $error("enabled falling edge gave no pulse");
  edge_gate_a: assert property (@(posedge CLK) disable iff (RST)
    !ENABLE |-> !FALL)
    else $error("edge pulse while pin enable clear");
endmodule : pio01_int_edge

// file: pio01_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to CLK
// Notes: the output moves only when stages two and three agree
module pio01_pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] PIN,
  output logic [W-1:0] LEVEL
);
  // stage one is read by stage two only
  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // shift chain
  always_ff @(posedge CLK) begin
    if (RST) begin
      meta <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      meta <= PIN;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // per bit, take the new level once two stages agree
  always_ff @(posedge CLK) begin
    if (RST) begin
      LEVEL <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          LEVEL[i] <= stage3[i];
        end
      end
    end
  end
endmodule : pio01_pin_sync

// file: pio01_pins.sv
// Purpose: board side of the two ports, pull-ups on the 8-bit port
// Assumes: 8-bit port is open drain, 6-bit port drives when enabled
// Notes: released bits show the board level, never the last drive
module pio01_pins (
  input wire logic [7:0] ext0,
  input wire logic [7:0] oe0,
  input wire logic [5:0] ext1,
  input wire logic [5:0] out1,
  input wire logic [5:0] oe1,
  output logic [7:0] p0,
  output logic [5:0] p1
);
  timeunit 1ns;
  timeprecision 1ps;
  // open drain: enabled bit pulls low, else board level
  assign p0 = ext0 & ~oe0;
  // driven bits carry the latch, inputs carry the board
  assign p1 = (oe1 & out1) | (~oe1 & ext1);
endmodule : pio01_pins

// file: pio01_pkg.sv
// Purpose: shared constants for the two-port parallel i/o block
// Assumes: 16-bit cpu address, 8-bit special function space data
// Notes: offsets are byte addresses inside the special function space
package pio01_pkg;
  // cpu address and data widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // width of the special function space offset
  localparam int SPACE_W = 6;
  // width of the 8-bit port and of the 6-bit port
  localparam int P0_W = 8;
  localparam int P1_W = 6;
  // upper address bits that must be zero to hit the space
  localparam logic [ADDR_W-SPACE_W-1:0] SPACE_PAGE = 10'h000;
  // register offsets
  localparam logic [SPACE_W-1:0] OFS_P0_LATCH = 6'h00;
  localparam logic [SPACE_W-1:0] OFS_P1_LATCH = 6'h01;
  localparam logic [SPACE_W-1:0] OFS_P0_PIN = 6'h08;
  localparam logic [SPACE_W-1:0] OFS_P1_DIR = 6'h0D;
  localparam logic [SPACE_W-1:0] OFS_EXT_INT_CTRL = 6'h37;
  // reset values
  localparam logic [P0_W-1:0] P0_LATCH_RST = 8'hFF;
  localparam logic [P1_W-1:0] P1_LATCH_RST = 6'h00;
  localparam logic [P1_W-1:0] P1_DIR_RST = 6'h00;
  localparam logic [DATA_W-1:0] EXT_INT_CTRL_RST = 8'h00;
  // idle level of the pins before the first sample
  localparam logic [P0_W-1:0] P0_PIN_RST = 8'hFF;
  localparam logic [P1_W-1:0] P1_PIN_RST = 6'h00;
  // position of the interrupt pin enable in the control register
  localparam int INT_PIN_EN_BIT = 6;
  // bit of the 8-bit port shared with the external interrupt
  localparam int INT_PORT_BIT = 0;
  // value read back for the unimplemented upper bits and holes
  localparam logic [DATA_W-1:0] READ_FILL = 8'h00;
  localparam logic [DATA_W-P1_W-1:0] P1_TOP_FILL = 2'h0;
endpackage : pio01_pkg

// file: pio01_top.sv
// Purpose: 8-bit port and 6-bit port of the cpu, special function space
// Assumes: the cpu gives one-cycle S1 and S2 strobes in each access
// Notes: reads sample in S1, writes land in S2; pins are synchronised
// How it works
// - outputs latched, inputs read live pins
// - pins sampled in read cycle S1
// - output latch updates in write S2
// - 8-bit port latch resets to ones
// - latch and pin input at separate addresses
// - bit zero is port or interrupt
// - bit zero is plain port after reset
// - enable bit six gates falling edges
// - direction bit one means output
// - 6-bit port direction and latch reset zero
// - 6-bit latch writable in any direction
// - 6-bit port bits seven, six undefined
// - read gives pin or latch per direction
// - space mapped at 0000H to 003FH
module pio01_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [pio01_pkg::ADDR_W-1:0] ADDR,
  input wire logic RD,
  input wire logic WR,
  input wire logic CYC_S1,
  input wire logic CYC_S2,
  input wire logic [pio01_pkg::DATA_W-1:0] WDATA,
  output logic [pio01_pkg::DATA_W-1:0] RDATA,
  output logic RDATA_VALID,
  output logic SPACE_SEL,
  input wire logic [pio01_pkg::P0_W-1:0] P0_IN,
  output logic [pio01_pkg::P0_W-1:0] P0_OUT,
  output logic [pio01_pkg::P0_W-1:0] P0_OE,
  input wire logic [pio01_pkg::P0_W-1:0] ALT0_OUT,
  output logic [pio01_pkg::P0_W-1:0] P0_LEVEL,
  input wire logic [pio01_pkg::P1_W-1:0] P1_IN,
  output logic [pio01_pkg::P1_W-1:0] P1_OUT,
  output logic [pio01_pkg::P1_W-1:0] P1_OE,
  output logic [pio01_pkg::P1_W-1:0] P1_LEVEL,
  output logic [pio01_pkg::DATA_W-1:0] EXT_INT_CTRL,
  output logic EXT_INT_ZERO_FALL
);
  // true when the cpu address hits one offset of the space
  function automatic logic hit(
    input logic [pio01_pkg::ADDR_W-1:0] a,
    input logic [pio01_pkg::SPACE_W-1:0] ofs
  );
    hit = (a[pio01_pkg::ADDR_W-1:pio01_pkg::SPACE_W] == pio01_pkg::SPACE_PAGE) &&
          (a[pio01_pkg::SPACE_W-1:0] == ofs);
  endfunction : hit

  // 6-bit port read value: latch where output, pin where input
  function automatic logic [pio01_pkg::P1_W-1:0] p1_mix(
    input logic [pio01_pkg::P1_W-1:0] dir,
    input logic [pio01_pkg::P1_W-1:0] lat,
    input logic [pio01_pkg::P1_W-1:0] pin
  );
    p1_mix = (dir & lat) | (~dir & pin);
  endfunction : p1_mix

  // storage latches and control
  logic [pio01_pkg::P0_W-1:0] p0_latch; // 8-bit port output latch
  logic [pio01_pkg::P1_W-1:0] p1_latch; // 6-bit port output latch
  logic [pio01_pkg::P1_W-1:0] p1_dir; // 6-bit port direction
  logic [pio01_pkg::DATA_W-1:0] ext_int_ctrl; // interrupt control byte
  // filtered pin levels
  logic [pio01_pkg::P0_W-1:0] p0_pin;
  logic [pio01_pkg::P1_W-1:0] p1_pin;
  // access strobes
  logic rd_go; // read sample point
  logic wr_go; // write update point
  logic int_pin_en; // bit zero given to the interrupt
  logic [pio01_pkg::DATA_W-1:0] next_rdata;

  // the read path samples pins in S1, the write path lands in S2
  assign rd_go = RD & CYC_S1;
  assign wr_go = WR & CYC_S2;
  assign int_pin_en = ext_int_ctrl[pio01_pkg::INT_PIN_EN_BIT];

  // decode of the whole space, seen by the cpu read mux
  assign SPACE_SEL =
    (ADDR[pio01_pkg::ADDR_W-1:pio01_pkg::SPACE_W] == pio01_pkg::SPACE_PAGE);

  // pin synchronisers; inputs carry no latch of their own
  pio01_pin_sync #(
    .W(pio01_pkg::P0_W),
    .INIT(pio01_pkg::P0_PIN_RST)
  ) u_p0_sync (
    .CLK(CLK),
    .RST(RST),
    .PIN(P0_IN),
    .LEVEL(p0_pin)
  );

  pio01_pin_sync #(
    .W(pio01_pkg::P1_W),
    .INIT(pio01_pkg::P1_PIN_RST)
  ) u_p1_sync (
    .CLK(CLK),
    .RST(RST),
    .PIN(P1_IN),
    .LEVEL(p1_pin)
  );

  // falling edge on bit zero, only while the interrupt owns it
  pio01_int_edge u_int_edge (
    .CLK(CLK),
    .RST(RST),
    .LEVEL(p0_pin[pio01_pkg::INT_PORT_BIT]),
    .ENABLE(int_pin_en),
    .FALL(EXT_INT_ZERO_FALL)
  );

  // 8-bit port latch: ones at reset, byte write in S2
  always_ff @(posedge CLK) begin
    if (RST) begin
      p0_latch <= pio01_pkg::P0_LATCH_RST;
    end else if (wr_go && hit(ADDR, pio01_pkg::OFS_P0_LATCH)) begin
      p0_latch <= WDATA;
    end
  end

  // 6-bit port latch: written whatever the direction
  always_ff @(posedge CLK) begin
    if (RST) begin
      p1_latch <= pio01_pkg::P1_LATCH_RST;
    end else if (wr_go && hit(ADDR, pio01_pkg::OFS_P1_LATCH)) begin
      p1_latch <= WDATA[pio01_pkg::P1_W-1:0];
    end
  end

  // 6-bit port direction; upper two bits are not stored
  always_ff @(posedge CLK) begin
    if (RST) begin
      p1_dir <= pio01_pkg::P1_DIR_RST;
    end else if (wr_go && hit(ADDR, pio01_pkg::OFS_P1_DIR)) begin
      p1_dir <= WDATA[pio01_pkg::P1_W-1:0];
    end
  end

  // interrupt control byte; bit six selects the bit zero use
  always_ff @(posedge CLK) begin
    if (RST) begin
      ext_int_ctrl <= pio01_pkg::EXT_INT_CTRL_RST;
    end else if (wr_go && hit(ADDR, pio01_pkg::OFS_EXT_INT_CTRL)) begin
      ext_int_ctrl <= WDATA;
    end
  end

  // read mux for the offsets held here
  always_comb begin
    next_rdata = pio01_pkg::READ_FILL;
    if (hit(ADDR, pio01_pkg::OFS_P0_LATCH)) begin
      // stored latch, not the pins
      next_rdata = p0_latch;
    end else if (hit(ADDR, pio01_pkg::OFS_P0_PIN)) begin
      // live pin levels, read only
      next_rdata = p0_pin;
    end else if (hit(ADDR, pio01_pkg::OFS_P1_LATCH)) begin
      // pins where input, latch where output
      next_rdata = {pio01_pkg::P1_TOP_FILL,
                    p1_mix(p1_dir, p1_latch, p1_pin)};
    end else if (hit(ADDR, pio01_pkg::OFS_P1_DIR)) begin
      // upper bits have no storage
      next_rdata = {pio01_pkg::P1_TOP_FILL, p1_dir};
    end else if (hit(ADDR, pio01_pkg::OFS_EXT_INT_CTRL)) begin
      next_rdata = ext_int_ctrl;
    end else begin
      // holes and offsets of other blocks read as fill
      next_rdata = pio01_pkg::READ_FILL;
    end
  end

  // read data captured at the S1 sample point
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= pio01_pkg::READ_FILL;
    end else if (rd_go && SPACE_SEL) begin
      RDATA <= next_rdata;
    end
  end

  // one-cycle mark that fresh read data stands
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= rd_go && SPACE_SEL;
    end
  end

  // 8-bit port drivers: a zero pulls low, bit zero released for interrupt
  always_comb begin
    P0_OUT = '0;
    P0_OE = ~(p0_latch & ALT0_OUT);
    if (int_pin_en) begin
      P0_OE[pio01_pkg::INT_PORT_BIT] = 1'b0;
    end
  end

  // 6-bit port drivers follow latch and direction
  assign P1_OUT = p1_latch;
  assign P1_OE = p1_dir;

  // pin levels for the alternate functions elsewhere
  assign P0_LEVEL = p0_pin;
  assign P1_LEVEL = p1_pin;
  assign EXT_INT_CTRL = ext_int_ctrl;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // write that lands on the 8-bit latch
  sequence p0_write_seq;
    wr_go && hit(ADDR, pio01_pkg::OFS_P0_LATCH);
  endsequence

  // read of the pin address at S1
  sequence p0_pin_read_seq;
    rd_go && hit(ADDR, pio01_pkg::OFS_P0_PIN);
  endsequence

  p0_reset_a: assert property (disable iff (1'b0)
    RST |=> (p0_latch == pio01_pkg::P0_LATCH_RST))
    else $error("8-bit latch not ones after reset");

  p1_reset_a: assert property (disable iff (1'b0)
    RST |=> (P1_OE == pio01_pkg::P1_DIR_RST) && (P1_OUT == pio01_pkg::P1_LATCH_RST))
    else $error("6-bit port not input and zero after reset");

  bit0_reset_a: assert property (disable iff (1'b0)
    RST |=> !int_pin_en && !EXT_INT_ZERO_FALL)
    else $error("bit zero not plain port after reset");

  p0_write_a: assert property (
    p0_write_seq |=> (p0_latch == $past(WDATA)))
    else $error("8-bit latch missed S2 write");

  p0_hold_a: assert property (
    !wr_go |=> $stable(p0_latch) && $stable(p1_latch) && $stable(p1_dir))
    else $error("latch changed outside S2 write");

  p0_pin_read_a: assert property (
    p0_pin_read_seq |=> RDATA_VALID && (RDATA == $past(p0_pin)))
    else $error("pin read not taken at S1");

  p1_mix_read_a: assert property (
    rd_go && hit(ADDR, pio01_pkg::OFS_P1_LATCH) |=>
      RDATA == {pio01_pkg::P1_TOP_FILL,
                ($past(p1_dir) & $past(p1_latch)) | (~$past(p1_dir) & $past(p1_pin))})
    else $error("6-bit port read mix wrong");

  p1_preload_a: assert property (
    wr_go && hit(ADDR, pio01_pkg::OFS_P1_LATCH) && (p1_dir == '0) |=>
      (P1_OUT == $past(WDATA[pio01_pkg::P1_W-1:0])) && (P1_OE == '0))
    else $error("preload while input lost or drove");

  p1_dir_a: assert property (
    wr_go && hit(ADDR, pio01_pkg::OFS_P1_DIR) |=>
      P1_OE == $past(WDATA[pio01_pkg::P1_W-1:0]))
    else $error("direction write not applied");

  bit0_release_a: assert property (
    int_pin_en |-> !P0_OE[pio01_pkg::INT_PORT_BIT])
    else $error("bit zero driven while interrupt owns it");

  out_of_space_a: assert property (
    RD && CYC_S1 && !SPACE_SEL |=> !RDATA_VALID && $stable(RDATA))
    else $error("read outside space answered");

  // write that lands on the interrupt control byte
  sequence ctrl_write_seq;
    wr_go && hit(ADDR, pio01_pkg::OFS_EXT_INT_CTRL);
  endsequence

  // read of the latch address at S1
  sequence p0_latch_read_seq;
    rd_go && hit(ADDR, pio01_pkg::OFS_P0_LATCH);
  endsequence

  // the control byte must follow the written byte one cycle later
  ctrl_write_a: assert property (
    ctrl_write_seq |=> (EXT_INT_CTRL == $past(WDATA)))
    else $error("control byte missed S2 write");

  // the latch address returns storage, never the pins
  p0_latch_read_a: assert property (
    p0_latch_read_seq |=> RDATA_VALID && (RDATA == $past(p0_latch)))
    else $error("latch read did not return the latch");

  // direction read back with the two missing bits filled
  p1_dir_read_a: assert property (
    rd_go && hit(ADDR, pio01_pkg::OFS_P1_DIR) |=>
      RDATA == {pio01_pkg::P1_TOP_FILL, $past(p1_dir)})
    else $error("direction read back wrong");

  // every in-space read is answered in the next cycle
  read_answer_a: assert property (
    rd_go && SPACE_SEL |=> RDATA_VALID)
    else $error("in-space read gave no valid mark");
endmodule : pio01_top

// file: tb_parallel_io_ports_zero_one.sv
// Purpose: self-checking bench of the two-port block against a model
// Assumes: one access per strobe, pins held steady before reads
// Notes: inputs move on the falling edge, model updated per write
module tb_parallel_io_ports_zero_one;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rd, wr, s1, s2;
  logic [15:0] addr;
  logic [7:0] wdata, alt, ext0;
  logic [5:0] ext1;
  wire [7:0] rdata, p0_in, p0_out, p0_oe, p0_lvl, eic;
  wire [5:0] p1_in, p1_out, p1_oe, p1_lvl;
  wire rvalid, sel, fall;
  // model state and bookkeeping
  logic [7:0] m_lat0, m_eic;
  logic [5:0] m_lat1, m_dir;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_fall = 0;
  int seed = 41;
  logic [5:0] ofs_tab [6] = '{6'h00, 6'h01, 6'h08, 6'h0D, 6'h37, 6'h00};
  pio01_top DUT (.CLK(clk), .RST(rst), .ADDR(addr), .RD(rd), .WR(wr),
    .CYC_S1(s1), .CYC_S2(s2), .WDATA(wdata), .RDATA(rdata),
    .RDATA_VALID(rvalid), .SPACE_SEL(sel), .P0_IN(p0_in), .P0_OUT(p0_out),
    .P0_OE(p0_oe), .ALT0_OUT(alt), .P0_LEVEL(p0_lvl), .P1_IN(p1_in),
    .P1_OUT(p1_out), .P1_OE(p1_oe), .P1_LEVEL(p1_lvl),
    .EXT_INT_CTRL(eic), .EXT_INT_ZERO_FALL(fall));
  pio01_pins pins (.ext0(ext0), .oe0(p0_oe), .ext1(ext1), .out1(p1_out),
    .oe1(p1_oe), .p0(p0_in), .p1(p1_in));
  // clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // count interrupt pulses as the design sees them
  always @(posedge clk) begin
    if (fall === 1'b1) n_fall++;
  end
  // verdict and end of run
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // compare one result
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // expected pin levels
  function automatic logic [7:0] pin0();
    logic [7:0] oe;
    oe = ~(m_lat0 & alt);
    if (m_eic[6]) oe[0] = 1'b0;
    return ext0 & ~oe;
  endfunction : pin0
  // expected read data for one offset
  function automatic logic [7:0] exp_rd(input logic [5:0] o);
    case (o)
      6'h00: return m_lat0;
      6'h01: return {2'h0, (m_dir & m_lat1) | (~m_dir & ext1)};
      6'h08: return pin0();
      6'h0D: return {2'h0, m_dir};
      6'h37: return m_eic;
      default: return 8'h00;
    endcase
  endfunction : exp_rd
  // one write access, taken at the S2 edge
  task automatic wrt(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr = 1'b1;
    wdata = d;
    s2 = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    s2 = 1'b0;
    if (a[15:6] == 10'h000) begin
      case (a[5:0])
        6'h00: m_lat0 = d;
        6'h01: m_lat1 = d[5:0];
        6'h0D: m_dir = d[5:0];
        6'h37: m_eic = d;
        default: ;
      endcase
    end
  endtask : wrt
  // one read access, answer in the cycle after S1
  task automatic rdc(input logic [15:0] a);
    logic hit;
    hit = (a[15:6] == 10'h000);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    s1 = 1'b1;
    #1 chk({7'h00, sel}, {7'h00, hit});
    @(negedge clk);
    rd = 1'b0;
    s1 = 1'b0;
    chk({7'h00, rvalid}, {7'h00, hit});
    if (hit) chk(rdata, exp_rd(a[5:0]));
  endtask : rdc
  // drive outputs against the model
  task automatic chk_pins();
    logic [7:0] oe;
    oe = ~(m_lat0 & alt);
    if (m_eic[6]) oe[0] = 1'b0;
    chk(p0_oe, oe);
    chk({2'h0, p1_oe}, {2'h0, m_dir});
    chk({2'h0, p1_out}, {2'h0, m_lat1});
  endtask : chk_pins
  // settled pin levels, control byte and low drive against the model
  task automatic chk_lvl();
    chk(p0_lvl, pin0());
    chk({2'h0, p1_lvl}, exp_rd(6'h01));
    chk(eic, m_eic);
    chk(p0_out, 8'h00);
  endtask : chk_lvl
  // reset design and model, then read every register
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    m_lat0 = 8'hFF;
    m_lat1 = 6'h00;
    m_dir = 6'h00;
    m_eic = 8'h00;
    repeat (6) @(negedge clk);
    foreach (ofs_tab[i]) rdc({10'h000, ofs_tab[i]});
    chk_pins();
  endtask : do_reset
  // watchdog
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test();
  end
  // main sequence
  initial begin
    {rd, wr, s1, s2} = 4'h0;
    addr = 16'h0000;
    wdata = 8'h00;
    alt = 8'hFF;
    ext0 = 8'hFF;
    ext1 = 6'h2A;
    do_reset();
    for (int k = 0; k < 10; k++) begin
      ext0 = $random(seed);
      ext1 = $random(seed);
      alt = $random(seed);
      wrt(16'h0000, $random(seed));
      wrt(16'h0001, $random(seed));
      wrt(16'h000D, $random(seed) | 8'hC0);
      wrt(16'h0037, $random(seed));
      chk_pins();
      repeat (8) @(negedge clk);
      chk_lvl();
      foreach (ofs_tab[i]) rdc({10'h000, ofs_tab[i]});
      rdc({10'h001, ofs_tab[k % 6]});
      if (k == 4) do_reset();
    end
    alt = 8'hFF;
    ext0 = 8'hFF;
    wrt(16'h0000, 8'hFF);
    wrt(16'h0037, 8'h00);
    repeat (8) @(negedge clk);
    n_fall = 0;
    ext0 = 8'hFE;
    repeat (10) @(negedge clk);
    chk(n_fall[7:0], 8'h00);
    ext0 = 8'hFF;
    wrt(16'h0037, 8'h40);
    repeat (10) @(negedge clk);
    ext0 = 8'hFE;
    repeat (10) @(negedge clk);
    chk(n_fall[7:0], 8'h01);
    rdc(16'h0008);
    rdc(16'h0037);
    chk_pins();
    chk_lvl();
    end_of_test();
  end
endmodule : tb_parallel_io_ports_zero_one
